// ===== src/cws_startup_ctrl.sv
// Function
// - Configuration word lives at 2007h, erased reads one
// - Configuration space reachable only in programming mode
// - Options follow bit values as read
// - Bit 13 always reads back one
// - Wake reset bit: continue or reset on wake
// - Bit 11 enables the clock monitor
// - Bit 10 enables oscillator switchover
// - Brown-out field selects four detection modes
// - Bit 7 zero protects data memory
// - Program protect zero blocks external reads
// - Bit 5 picks reset or alternate pin
// - Bit 4 zero enables the power-up timer
// - Bit 3 forces watchdog, else software enable
// - Start-up timer holds off run until crystal stable; reset stays released if a wake continues
// - Power-up timer holds 64 ms on power-up
// - Brown-out resets, optionally plus 64 ms
// - Sleep wakes on reset, watchdog or interrupt
// - Internal reset tied inactive, pull-up when pin alternate
// - Power-up timer after power-on, then start-up timer
// Purpose: Holds and decodes the configuration word and sequences start-up reset
// Assumes: Programmer address and data are stable before its write strobe
// Notes: Word store resets to erased; a real part keeps it in flash
`default_nettype none
module cws_startup_ctrl #(
    parameter int POWERUP_CYCLES = cws_pkg::POWERUP_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Programmer pins
    input wire logic progModePin,
    input wire logic progWritePin,
    input wire logic [13:0] progAddr,
    input wire logic [13:0] progData,
    output logic [13:0] progReadData,
    // Supply, master clear and oscillator pins
    input wire logic porDonePin,
    input wire logic brownoutLowPin,
    input wire logic masterClearPin_n,
    input wire logic oscTickPin,
    // Core requests
    input wire logic sleepReq,
    input wire logic watchdogWake,
    input wire logic interruptWake,
    input wire logic softwareBrownoutEnable,
    input wire logic softwareWatchdogEnable,
    // Sequencer status
    output logic deviceReset,
    output logic sleeping,
    output logic wakeContinue,
    // Decoded configuration
    output logic wakeResetEnable,
    output logic clockMonitorEnable,
    output logic oscSwitchoverEnable,
    output logic brownoutDetectEnable,
    output logic softwareBrownoutAllowed,
    output logic dataMemoryProtect,
    output logic programMemoryProtect,
    output logic masterClearPinReset,
    output logic masterClearPullupEn,
    output logic watchdogEnable,
    output logic watchdogSoftwareAllowed,
    output logic [2:0] oscillatorSelect
);
    localparam logic [cws_pkg::TMR_W-1:0] PWR_LOAD = cws_pkg::TMR_W'(POWERUP_CYCLES - 1);
    localparam logic [cws_pkg::TMR_W-1:0] OSC_LOAD = cws_pkg::TMR_W'(cws_pkg::OSC_START_PERIODS);

    logic [cws_pkg::SYNC_W-1:0] pinSync;
    logic [2*cws_pkg::CFG_W-1:0] busSync;
    logic [13:0] progAddrSync;
    logic [13:0] progDataSync;
    logic progMode;
    logic progWrite;
    logic porDone;
    logic brownoutLow;
    logic masterClearLow;
    logic oscTick;
    logic progWritePrev_r;
    logic oscTickPrev_r;
    logic [13:0] cfgWord_r;
    logic [13:0] cfgLatched_r;
    logic [13:0] progReadData_r;
    cws_pkg::cws_state_e state_r;

    cws_sync #(
        .WIDTH(cws_pkg::SYNC_W)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pinIn({progModePin, progWritePin, porDonePin, brownoutLowPin, !masterClearPin_n, oscTickPin}),
        .syncOut(pinSync)
    );

    // Bus is settled well before the synced strobe, so both arrive aligned
    cws_sync #(
        .WIDTH(2 * cws_pkg::CFG_W)
    ) u_bus_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pinIn({progAddr, progData}),
        .syncOut(busSync)
    );
    assign {progAddrSync, progDataSync} = busSync;

    assign {progMode, progWrite, porDone, brownoutLow, masterClearLow, oscTick} = pinSync;

    // Programmer access, gated by programming mode
    wire writeEdge = progWrite && !progWritePrev_r;
    wire inCfgSpace = (progAddrSync >= cws_pkg::CFG_SPACE_LO) && (progAddrSync <= cws_pkg::CFG_SPACE_HI);
    wire cfgHit = progMode && inCfgSpace && (progAddrSync == cws_pkg::CFG_ADDR);
    wire [13:0] cfgStored = progDataSync | (14'h0001 << cws_pkg::B_UNUSED);
    wire [13:0] readNxt = cfgHit ? cfgWord_r : cws_pkg::READ_NONE;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            progWritePrev_r <= 1'b0;
            oscTickPrev_r <= 1'b0;
            cfgWord_r <= cws_pkg::CFG_ERASED;
            progReadData_r <= cws_pkg::READ_NONE;
        end else begin
            progWritePrev_r <= progWrite;
            oscTickPrev_r <= oscTick;
            if (writeEdge && cfgHit) begin
                cfgWord_r <= cfgStored;
            end
            progReadData_r <= readNxt;
        end
    end

    assign progReadData = progReadData_r;

    // Fields of the latched word; polarity as read
    wire crystalMode = (cfgLatched_r[cws_pkg::B_OSC_HI:cws_pkg::B_OSC_LO] == cws_pkg::OSC_LOW_POWER_XTAL)
        || (cfgLatched_r[cws_pkg::B_OSC_HI:cws_pkg::B_OSC_LO] == cws_pkg::OSC_XTAL)
        || (cfgLatched_r[cws_pkg::B_OSC_HI:cws_pkg::B_OSC_LO] == cws_pkg::OSC_HIGH_SPEED_XTAL);
    wire powerupEnabled = !cfgLatched_r[cws_pkg::B_PWR_TMR];
    wire wakeResets = !cfgLatched_r[cws_pkg::B_WAKE_RST];
    wire pinIsReset = cfgLatched_r[cws_pkg::B_MASTER_CLEAR_PIN_SEL];
    wire masterClear = pinIsReset && masterClearLow;
    wire [1:0] brnMode = cfgLatched_r[cws_pkg::B_BRN_HI:cws_pkg::B_BRN_LO];
    wire inSleep = (state_r == cws_pkg::ST_SLEEP);
    wire brnAlways = (brnMode == cws_pkg::BRN_ALWAYS);
    wire brnRun = (brnMode == cws_pkg::BRN_RUN_ONLY) && !inSleep;
    wire brnSoft = (brnMode == cws_pkg::BRN_SOFTWARE) && softwareBrownoutEnable;
    wire brnEnable = brnAlways || brnRun || brnSoft;
    wire brownoutTrip = brnEnable && brownoutLow;
    wire oscTickEdge = oscTick && !oscTickPrev_r;
    wire anyWake = masterClear || watchdogWake || interruptWake;

    // Timers
    logic powerupDone;
    logic oscStartDone;

    cws_timer #(
        .WIDTH(cws_pkg::TMR_W),
        .LOAD(PWR_LOAD)
    ) u_powerup_tmr (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(state_r == cws_pkg::ST_POWERUP),
        .tick(1'b1),
        .done(powerupDone)
    );

    cws_timer #(
        .WIDTH(cws_pkg::TMR_W),
        .LOAD(OSC_LOAD)
    ) u_osc_start_tmr (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(state_r == cws_pkg::ST_OSC_START),
        .tick(oscTickEdge),
        .done(oscStartDone)
    );

    // Sequencer
    cws_pkg::cws_state_e state_nxt;
    logic inReset_r;
    logic inReset_nxt;
    logic powerupArm_r;
    logic powerupArm_nxt;
    logic oscArm_r;
    logic oscArm_nxt;
    logic wakeContinue_r;
    logic wakeContinue_nxt;
    logic brownoutDetectEnable_r;

    // Power loss and brown-out restart the timers; master clear only holds
    wire coldEvent = !porDone || brownoutTrip;
    wire holdExitNext = powerupArm_r && powerupEnabled;

    always_comb begin
        state_nxt = state_r;
        inReset_nxt = inReset_r;
        powerupArm_nxt = powerupArm_r;
        oscArm_nxt = oscArm_r;
        wakeContinue_nxt = 1'b0;
        if (coldEvent) begin
            state_nxt = cws_pkg::ST_HOLD;
            inReset_nxt = 1'b1;
            powerupArm_nxt = 1'b1;
            oscArm_nxt = 1'b1;
        end else begin
            unique case (state_r)
                cws_pkg::ST_HOLD: begin
                    if (!masterClear) begin
                        if (holdExitNext) begin
                            state_nxt = cws_pkg::ST_POWERUP;
                        end else if (oscArm_r && crystalMode) begin
                            state_nxt = cws_pkg::ST_OSC_START;
                        end else begin
                            state_nxt = cws_pkg::ST_RUN;
                            inReset_nxt = 1'b0;
                        end
                        powerupArm_nxt = 1'b0;
                    end
                end
                cws_pkg::ST_POWERUP: begin
                    if (powerupDone) begin
                        if (oscArm_r && crystalMode) begin
                            state_nxt = cws_pkg::ST_OSC_START;
                        end else begin
                            state_nxt = cws_pkg::ST_RUN;
                            inReset_nxt = 1'b0;
                        end
                    end
                end
                cws_pkg::ST_OSC_START: begin
                    if (masterClear && !inReset_r) begin
                        state_nxt = cws_pkg::ST_HOLD;
                        inReset_nxt = 1'b1;
                    end else if (oscStartDone) begin
                        state_nxt = cws_pkg::ST_RUN;
                        inReset_nxt = 1'b0;
                        oscArm_nxt = 1'b0;
                    end
                end
                cws_pkg::ST_RUN: begin
                    oscArm_nxt = 1'b0;
                    if (masterClear) begin
                        state_nxt = cws_pkg::ST_HOLD;
                        inReset_nxt = 1'b1;
                    end else if (sleepReq) begin
                        state_nxt = cws_pkg::ST_SLEEP;
                    end
                end
                cws_pkg::ST_SLEEP: begin
                    if (masterClear) begin
                        state_nxt = cws_pkg::ST_HOLD;
                        inReset_nxt = 1'b1;
                    end else if (anyWake && wakeResets) begin
                        state_nxt = cws_pkg::ST_HOLD;
                        inReset_nxt = 1'b1;
                        oscArm_nxt = 1'b1;
                    end else if (anyWake) begin
                        wakeContinue_nxt = 1'b1;
                        oscArm_nxt = 1'b1;
                        state_nxt = crystalMode ? cws_pkg::ST_OSC_START : cws_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_nxt = cws_pkg::ST_HOLD;
                    inReset_nxt = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= cws_pkg::ST_HOLD;
            inReset_r <= 1'b1;
            powerupArm_r <= 1'b1;
            oscArm_r <= 1'b1;
            wakeContinue_r <= 1'b0;
            cfgLatched_r <= cws_pkg::CFG_ERASED;
            brownoutDetectEnable_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            inReset_r <= inReset_nxt;
            powerupArm_r <= powerupArm_nxt;
            oscArm_r <= oscArm_nxt;
            wakeContinue_r <= wakeContinue_nxt;
            brownoutDetectEnable_r <= brnEnable;
            if (inReset_r) begin
                cfgLatched_r <= cfgWord_r;
            end
        end
    end

    // Outputs; decodes come from the latched word, with watchdog and brown-out enables also taking software inputs
    assign deviceReset = inReset_r;
    assign sleeping = inSleep;
    assign wakeContinue = wakeContinue_r;
    assign wakeResetEnable = cfgLatched_r[cws_pkg::B_WAKE_RST];
    assign clockMonitorEnable = cfgLatched_r[cws_pkg::B_CLK_MON];
    assign oscSwitchoverEnable = cfgLatched_r[cws_pkg::B_SWITCH];
    assign brownoutDetectEnable = brownoutDetectEnable_r;
    assign softwareBrownoutAllowed = (brnMode == cws_pkg::BRN_SOFTWARE);
    assign dataMemoryProtect = !cfgLatched_r[cws_pkg::B_DATA_PROT];
    assign programMemoryProtect = !cfgLatched_r[cws_pkg::B_PROG_PROT];
    assign masterClearPinReset = pinIsReset;
    assign masterClearPullupEn = !pinIsReset;
    assign watchdogSoftwareAllowed = !cfgLatched_r[cws_pkg::B_WATCHDOG];
    assign watchdogEnable = cfgLatched_r[cws_pkg::B_WATCHDOG] || softwareWatchdogEnable;
    assign oscillatorSelect = cfgLatched_r[cws_pkg::B_OSC_HI:cws_pkg::B_OSC_LO];

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Cycles spent in the power-up hold
    logic [cws_pkg::TMR_W-1:0] powerupSpan_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            powerupSpan_r <= '0;
        end else begin
            powerupSpan_r <= (state_r == cws_pkg::ST_POWERUP) ? powerupSpan_r + 1'b1 : '0;
        end
    end

    unused_bit_a: assert property (cfgWord_r[cws_pkg::B_UNUSED] && cfgLatched_r[cws_pkg::B_UNUSED])
        else $error("unimplemented bit not one");
    prog_gate_a: assert property (!progMode |=> $stable(cfgWord_r))
        else $error("word changed outside programming mode");
    wake_reset_a: assert property ((inSleep && !coldEvent && anyWake && wakeResets)
        |=> (state_r == cws_pkg::ST_HOLD) && deviceReset)
        else $error("wake did not reset");
    wake_cont_a: assert property ((inSleep && !coldEvent && !masterClear && anyWake && !wakeResets)
        |=> wakeContinue && !deviceReset)
        else $error("wake did not continue");
    brn_off_a: assert property ((brnMode == cws_pkg::BRN_OFF)
        |-> !softwareBrownoutAllowed ##1 !brownoutDetectEnable)
        else $error("brown-out on in off mode");
    powerup_len_a: assert property (($past(state_r) == cws_pkg::ST_POWERUP) && (state_r != cws_pkg::ST_POWERUP)
        && (state_r != cws_pkg::ST_HOLD) |-> powerupSpan_r == PWR_LOAD + 1'b1)
        else $error("power-up hold length wrong");
    powerup_skip_a: assert property ((state_r == cws_pkg::ST_HOLD) && !powerupEnabled
        |=> state_r != cws_pkg::ST_POWERUP)
        else $error("power-up timer ran while disabled");
    osc_hold_a: assert property ((state_r == cws_pkg::ST_OSC_START) && !oscStartDone && !masterClear
        |=> state_r != cws_pkg::ST_RUN)
        else $error("left start-up before crystal stable");
    brn_reset_a: assert property ((state_r == cws_pkg::ST_RUN) && brownoutTrip
        |=> deviceReset && (state_r == cws_pkg::ST_HOLD))
        else $error("brown-out did not reset");
    sleep_hold_a: assert property (inSleep && !anyWake && !coldEvent |=> inSleep)
        else $error("left sleep without wake source");
    pin_alt_a: assert property (!pinIsReset |-> masterClearPullupEn && !masterClear)
        else $error("alternate pin still resets");
    latch_hold_a: assert property (!deviceReset ##1 !deviceReset |-> $stable(oscillatorSelect)
        && $stable(clockMonitorEnable) && $stable(programMemoryProtect))
        else $error("decoded word changed while running");

    cov_powerup_c: cover property ((state_r == cws_pkg::ST_POWERUP) ##1 (state_r == cws_pkg::ST_OSC_START));
    cov_wake_rst_c: cover property (inSleep ##1 (state_r == cws_pkg::ST_HOLD));
    cov_wake_cont_c: cover property (wakeContinue);
    cov_brownout_c: cover property ((state_r == cws_pkg::ST_RUN) ##1 brownoutTrip);
endmodule
`default_nettype wire

// ===== src/cws_pkg.sv
// Purpose: Shared constants and types for the configuration word and start-up control
// Assumes: 100 MHz system clock
// Notes: Erased option bits read as one
`default_nettype none
package cws_pkg;
    localparam int CFG_W = 14;
    localparam logic [13:0] CFG_ADDR = 14'h2007;
    localparam logic [13:0] CFG_SPACE_LO = 14'h2000;
    localparam logic [13:0] CFG_SPACE_HI = 14'h3fff;
    localparam logic [13:0] CFG_ERASED = 14'h3fff;
    localparam logic [13:0] READ_NONE = 14'h0000;
    localparam int B_UNUSED = 13;
    localparam int B_WAKE_RST = 12;
    localparam int B_CLK_MON = 11;
    localparam int B_SWITCH = 10;
    localparam int B_BRN_HI = 9;
    localparam int B_BRN_LO = 8;
    localparam int B_DATA_PROT = 7;
    localparam int B_PROG_PROT = 6;
    localparam int B_MASTER_CLEAR_PIN_SEL = 5;
    localparam int B_PWR_TMR = 4;
    localparam int B_WATCHDOG = 3;
    localparam int B_OSC_HI = 2;
    localparam int B_OSC_LO = 0;
    localparam int SYNC_W = 6;
    localparam int POWERUP_TIME_US = 64000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int POWERUP_CYCLES = POWERUP_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int OSC_START_PERIODS = 1024;
    localparam int TMR_W = 23;
    typedef enum logic [2:0] {
        OSC_LOW_POWER_XTAL = 3'h0,
        OSC_XTAL = 3'h1,
        OSC_HIGH_SPEED_XTAL = 3'h2,
        OSC_EXT_CLOCK = 3'h3,
        OSC_INTERNAL_IO = 3'h4,
        OSC_INTERNAL_CLKOUT = 3'h5,
        OSC_EXT_RC_IO = 3'h6,
        OSC_EXT_RC_CLKOUT = 3'h7
    } cws_osc_e;
    typedef enum logic [1:0] {
        BRN_OFF = 2'h0,
        BRN_SOFTWARE = 2'h1,
        BRN_RUN_ONLY = 2'h2,
        BRN_ALWAYS = 2'h3
    } cws_brn_e;
    typedef enum logic [2:0] {
        ST_HOLD = 3'h0,
        ST_POWERUP = 3'h1,
        ST_OSC_START = 3'h2,
        ST_RUN = 3'h3,
        ST_SLEEP = 3'h4
    } cws_state_e;
endpackage
`default_nettype wire

// ===== src/cws_sync.sv
// Purpose: Two-stage synchroniser for asynchronous pins
// Assumes: Each bit is an independent level
// Notes: First stage is read only by the second
`default_nettype none
module cws_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Levels
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage1_r <= '0;
            stage2_r <= '0;
        end else begin
            stage1_r <= pinIn;
            stage2_r <= stage1_r;
        end
    end

    assign syncOut = stage2_r;
endmodule
`default_nettype wire

// ===== src/cws_timer.sv
// Purpose: Reset-hold timer counting enable ticks up to a load value
// Assumes: run low clears the count
// Notes: done stays high until run drops
`default_nettype none
module cws_timer #(
    parameter int WIDTH = 23,
    parameter logic [WIDTH-1:0] LOAD = '1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic tick,
    output logic done
);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;

    assign done = (cnt_r == LOAD);
    assign cnt_nxt = !run ? '0 : (tick && !done) ? cnt_r + 1'b1 : cnt_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// ===== src/cws_fix_note.sv
`default_nettype none
`default_nettype wire

// ===== tb/cws_prog_model.sv
// Purpose: Behavioural programmer for the configuration word pins
// Assumes: Tasks are called from the bench clock domain
// Notes: Released data lines show the inverse of their last value
`default_nettype none
module cws_prog_model (
    // Clock
    input wire logic clk_sys,
    // Programmer pins
    output logic progModePin,
    output logic progWritePin,
    output logic [13:0] progAddr,
    output logic [13:0] progData,
    input wire logic [13:0] progReadData
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        progModePin = 1'b0;
        progWritePin = 1'b0;
        progAddr = 14'h0000;
        progData = 14'h0000;
    end
    // Mode settles through the sync before any access
    task automatic set_mode(input logic m);
        @(posedge clk_sys);
        progModePin <= m;
        repeat (4) @(posedge clk_sys);
    endtask
    task automatic write_word(input logic [13:0] a, input logic [13:0] d);
        @(posedge clk_sys);
        progAddr <= a;
        progData <= d;
        repeat (3) @(posedge clk_sys);
        progWritePin <= 1'b1;
        // Address held well past the synchronised strobe edge
        repeat (6) @(posedge clk_sys);
        progWritePin <= 1'b0;
        repeat (3) @(posedge clk_sys);
        progData <= ~d;
    endtask
    task automatic read_word(input logic [13:0] a, output logic [13:0] d);
        @(posedge clk_sys);
        progAddr <= a;
        repeat (4) @(posedge clk_sys);
        #1 d = progReadData;
    endtask
endmodule
`default_nettype wire

// ===== tb/test_config_word_startup_control.sv
// Purpose: Self-checking bench for the configuration word and start-up control
// Assumes: Power-up count shortened to keep the run short
// Notes: Oscillator ticks arrive every fourth clock
`default_nettype none
module test_config_word_startup_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PWR = 20;
    logic clk_sys, rst_n, pm, pw, por, brn, master_clear_pin_n, slp, wdw, irw, swBrn, swWdt, tick;
    logic dr, sl, wc, wre, cme, ose, bde, sba, dmp, pmp, mcr, mpu, wde, wsa;
    logic [2:0] osel;
    logic [1:0] tickCnt = 2'h0;
    logic [13:0] pa, pd, prd, decoded, w, r;
    int fail_count = 0, total_checks = 0, n;
    int lo[5] = '{PWR, 0, 4080, 4080, PWR + 4080};
    int hi[5] = '{PWR + 8, 8, 4112, 4112, PWR + 4112};
    logic [13:0] tw[5] = '{14'h3fec, 14'h3ffc, 14'h3ff8, 14'h3ffa, 14'h3fe9};
    assign decoded = {wre, cme, ose, bde, sba, dmp, pmp, mcr, mpu, wde, wsa, osel};
    assign tick = tickCnt[1];
    cws_prog_model cws_prog_model_inst (.clk_sys(clk_sys), .progModePin(pm), .progWritePin(pw), .progAddr(pa),
        .progData(pd), .progReadData(prd));
    cws_startup_ctrl #(.POWERUP_CYCLES(PWR)) cws_startup_ctrl_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .progModePin(pm), .progWritePin(pw), .progAddr(pa), .progData(pd), .progReadData(prd),
        .porDonePin(por), .brownoutLowPin(brn), .masterClearPin_n(master_clear_pin_n), .oscTickPin(tick), .sleepReq(slp),
        .watchdogWake(wdw), .interruptWake(irw), .softwareBrownoutEnable(swBrn), .softwareWatchdogEnable(swWdt),
        .deviceReset(dr), .sleeping(sl), .wakeContinue(wc), .wakeResetEnable(wre), .clockMonitorEnable(cme),
        .oscSwitchoverEnable(ose), .brownoutDetectEnable(bde), .softwareBrownoutAllowed(sba),
        .dataMemoryProtect(dmp), .programMemoryProtect(pmp), .masterClearPinReset(mcr),
        .masterClearPullupEn(mpu), .watchdogEnable(wde), .watchdogSoftwareAllowed(wsa), .oscillatorSelect(osel));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) tickCnt <= tickCnt + 2'h1;
    function automatic logic [13:0] exp_dec(input logic [13:0] v, input logic sb, input logic sw);
        logic be;
        be = (v[9:8] == 2'h1) ? sb : v[9];
        return {v[12], v[11], v[10], be, v[9:8] == 2'h1, ~v[7], ~v[6], v[5], ~v[5], v[3] | sw, ~v[3], v[2:0]};
    endfunction
    task automatic chk(input logic [13:0] e, input logic [13:0] a);
        total_checks++;
        if (a !== e) begin
            fail_count++;
            $display("[ERR] t=%0t exp=%h act=%h", $time, e, a);
        end
    endtask
    task automatic wait_run(output int k);
        k = 0;
        do begin
            @(posedge clk_sys);
            #1 k++;
        end while (dr !== 1'b0 && k < 6000);
    endtask
    // Decodes relatch only in reset, so a cold reset follows each write
    task automatic load(input logic [13:0] v, output int k);
        cws_prog_model_inst.write_word(cws_pkg::CFG_ADDR, v);
        @(posedge clk_sys);
        por <= 1'b0;
        swBrn <= 1'($urandom);
        swWdt <= 1'($urandom);
        repeat (4) @(posedge clk_sys);
        por <= 1'b1;
        wait_run(k);
    endtask
    task automatic nap();
        @(posedge clk_sys);
        slp <= 1'b1;
        @(posedge clk_sys);
        slp <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 chk(14'h1, {13'h0, sl});
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clk_sys);
        fail_count++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h3f08868e));
        {rst_n, brn, slp, wdw, irw, swBrn, swWdt} = 7'h0;
        por = 1'b1;
        master_clear_pin_n = 1'b1;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1 chk(exp_dec(14'h3fff, swBrn, swWdt), decoded);
        chk(14'h1, {13'h0, dr});
        wait_run(n);
        $display("test reset done");
        cws_prog_model_inst.set_mode(1'b1);
        cws_prog_model_inst.read_word(cws_pkg::CFG_ADDR, r);
        chk(14'h3fff, r);
        for (int i = 0; i < 4; i++) begin
            w = 14'($urandom);
            cws_prog_model_inst.write_word(cws_pkg::CFG_ADDR, w);
            cws_prog_model_inst.read_word(cws_pkg::CFG_ADDR, r);
            chk(w | 14'h2000, r);
            cws_prog_model_inst.write_word(14'h2000 + 14'(i), ~w);
            cws_prog_model_inst.read_word(cws_pkg::CFG_ADDR, r);
            chk(w | 14'h2000, r);
            cws_prog_model_inst.read_word(14'h2000 + 14'(i), r);
            chk(14'h0, r);
        end
        cws_prog_model_inst.set_mode(1'b0);
        cws_prog_model_inst.write_word(cws_pkg::CFG_ADDR, ~w);
        cws_prog_model_inst.read_word(cws_pkg::CFG_ADDR, r);
        chk(14'h0, r);
        cws_prog_model_inst.set_mode(1'b1);
        cws_prog_model_inst.read_word(cws_pkg::CFG_ADDR, r);
        chk(w | 14'h2000, r);
        $display("test program done");
        for (int i = 0; i < 8; i++) begin
            w = (i == 0) ? 14'h0004 : 14'($urandom) | 14'h2004;
            w[9:8] = 2'(i);
            load(w, n);
            chk(exp_dec(w, swBrn, swWdt), decoded);
        end
        $display("test decode done");
        for (int j = 0; j < 5; j++) begin
            load(tw[j], n);
            chk(14'h1, {13'h0, n >= lo[j] && n <= hi[j]});
            chk(exp_dec(tw[j], swBrn, swWdt), decoded);
        end
        $display("test timing done");
        @(posedge clk_sys);
        brn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 chk(14'h1, {13'h0, dr});
        @(posedge clk_sys);
        brn <= 1'b0;
        wait_run(n);
        chk(14'h1, {13'h0, n >= lo[4] && n <= hi[4]});
        $display("test brownout done");
        load(14'h3efc, n);
        nap();
        chk(14'h0, {13'h0, bde});
        @(posedge clk_sys);
        irw <= 1'b1;
        @(posedge clk_sys);
        irw <= 1'b0;
        #1 chk(14'h2, {12'h0, wc, dr});
        load(14'h2ffc, n);
        nap();
        @(posedge clk_sys);
        wdw <= 1'b1;
        @(posedge clk_sys);
        wdw <= 1'b0;
        #1 chk(14'h1, {12'h0, wc, dr});
        wait_run(n);
        @(posedge clk_sys);
        master_clear_pin_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 chk(14'h1, {13'h0, dr});
        @(posedge clk_sys);
        master_clear_pin_n <= 1'b1;
        wait_run(n);
        load(14'h3fdc, n);
        @(posedge clk_sys);
        master_clear_pin_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 chk(14'h1, {12'h0, dr, mpu});
        @(posedge clk_sys);
        master_clear_pin_n <= 1'b1;
        $display("test sleep and pin done");
        stop_test();
    end
endmodule
`default_nettype wire
